// file: mzs_map.svh
// Register map, field positions, reset values and timing constants
// How it works
// - Muting starts when one muting input rises while the other is already high, either first.
// - Muting starts only if the second rise comes within the activation limit of 1 to 16 s.
// - An active muting ends when the maximum muting duration expires, whatever the inputs do.
// - A falling muting input ends muting after an internal delay of at most 30 ms.
// - A muting timer starts with muting; at its limit (10 min default) muting ends, safe state.
// - While muting with no zone fault, the safety switching output stays ON.
// - Input side and output side are never muted at the same time.
// - Muting cannot start while the device is in its safe state.
// - Muting is shown on the lamp output and on the status display.
// - Invalid zone codes inside the switchover window are not a fault.
// - The switchover window is set in steps of 30 ms.
`ifndef MZS_MAP_SVH
`define MZS_MAP_SVH
`define MZS_CLK_MHZ 20
`define MZS_MS_US 1000
`define MZS_SEC_MS 1000
`define MZS_STEP_MS 30
`define MZS_OFF_MS 30
`define MZS_ADDR_CFG0 12'h000
`define MZS_ADDR_CFG1 12'h004
`define MZS_ADDR_STAT 12'h008
`define MZS_ACT_LSB 0
`define MZS_WIN_LSB 8
`define MZS_EN_BIT 16
`define MZS_ACT_RST 4'h3
`define MZS_EN_RST 1'b1
`define MZS_WIN_RST 8'h04
`define MZS_MAXDUR_RST 16'h0258
`endif

// file: mzs_pkg.sv
// Types of the muting and zone select block
package mzs_pkg;
  typedef enum logic [2:0] {
    MZS_WAIT,
    MZS_IDLE,
    MZS_ARMED,
    MZS_MUTED,
    MZS_OFFDLY
  } mzs_state_t;
  typedef logic [3:0] mzs_zone_t;
endpackage

// file: mzs_ctrl.sv
// Muting state machine, zone selection window and APB registers
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "mzs_map.svh"
module mzs_ctrl
  import mzs_pkg::*;
#(
  parameter int MS_CYC = `MZS_MS_US * `MZS_CLK_MHZ
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic mute_a,
  input wire logic mute_b,
  input wire mzs_pkg::mzs_zone_t zone_sel,
  input wire logic object_detect,
  // Machine side
  output logic safety_switch_output,
  output logic mute_lamp
);
  import mzs_pkg::*;

  function automatic logic onehot(input mzs_zone_t z);
    onehot = (z != 4'h0) && ((z & (z - 4'h1)) == 4'h0);
  endfunction

  // Pin synchronisers
  logic [5:0] s1_q, s2_q, s1_d, s2_d;
  always_comb begin
    s1_d = {zone_sel, mute_b, mute_a};
    s2_d = s1_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  logic a_s, b_s;
  mzs_zone_t z_s;
  assign a_s = s2_q[0];
  assign b_s = s2_q[1];
  assign z_s = s2_q[5:2];

  // Free running millisecond tick
  logic [15:0] pre_q, pre_d;
  logic ms_tick, sec_tick;
  assign ms_tick = (pre_q == 16'(MS_CYC - 1));
  always_comb begin
    pre_d = ms_tick ? 16'h0000 : pre_q + 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_d;
    end
  end

  // Configuration registers
  logic [3:0] act_q, act_d;
  logic [7:0] win_q, win_d;
  logic en_q, en_d;
  logic [15:0] maxdur_q, maxdur_d;

  // Zone selection
  mzs_zone_t zprev_q, zprev_d, zone_q, zone_d;
  logic [12:0] wms_q, wms_d;
  logic wact_q, wact_d, zflt_q, zflt_d;
  logic [12:0] win_ms;
  assign win_ms = 13'(win_q) * 13'(`MZS_STEP_MS);
  always_comb begin
    zprev_d = z_s;
    zone_d = zone_q;
    wms_d = wms_q;
    wact_d = wact_q;
    zflt_d = zflt_q;
    if (z_s != zprev_q) begin
      wact_d = 1'b1;
      wms_d = 13'h0000;
    end else if (wact_q) begin
      if (wms_q >= win_ms) begin
        wact_d = 1'b0;
        zflt_d = !onehot(z_s);
        if (onehot(z_s)) begin
          zone_d = z_s;
        end
      end else if (ms_tick) begin
        wms_d = wms_q + 13'h0001;
      end
    end else if (!onehot(z_s)) begin
      zflt_d = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zprev_q <= 4'h0;
      zone_q <= 4'h0;
      wms_q <= 13'h0000;
      wact_q <= 1'b1;
      zflt_q <= 1'b0;
    end else begin
      zprev_q <= zprev_d;
      zone_q <= zone_d;
      wms_q <= wms_d;
      wact_q <= wact_d;
      zflt_q <= zflt_d;
    end
  end

  // Muting state machine
  mzs_state_t st_q, st_d;
  logic [13:0] ams_q, ams_d;
  logic [15:0] dur_q, dur_d;
  logic [4:0] off_q, off_d;
  logic [9:0] mms_q, mms_d;
  logic tmo_q, tmo_d, side_q, side_d;
  logic safe, muting, both, late;
  logic [13:0] act_ms;
  assign act_ms = (14'(act_q) + 14'h0001) * 14'(`MZS_SEC_MS);
  assign both = a_s && b_s;
  assign late = ams_q > act_ms;
  assign safe = object_detect || zflt_q || tmo_q;
  assign muting = (st_q == MZS_MUTED) || (st_q == MZS_OFFDLY);
  // Seconds counted from muting start, not from a free running divider
  assign sec_tick = ms_tick && (mms_q == 10'(`MZS_SEC_MS - 1));
  always_comb begin
    st_d = st_q;
    mms_d = mms_q;
    ams_d = ams_q;
    dur_d = dur_q;
    off_d = off_q;
    tmo_d = tmo_q;
    side_d = side_q;
    unique case (st_q)
      MZS_WAIT: begin
        if (!a_s && !b_s) begin
          st_d = MZS_IDLE;
          tmo_d = 1'b0;
        end
      end
      MZS_IDLE: begin
        ams_d = 14'h0000;
        side_d = a_s;
        if (both && en_q && !safe) begin
          st_d = MZS_MUTED;
          dur_d = 16'h0000;
          mms_d = 10'h000;
        end else if (a_s || b_s) begin
          st_d = MZS_ARMED;
        end
      end
      MZS_ARMED: begin
        if (ms_tick) begin
          ams_d = ams_q + 14'h0001;
        end
        if (!a_s && !b_s) begin
          st_d = MZS_IDLE;
        end else if (late) begin
          st_d = MZS_WAIT;
        end else if (both && en_q && !safe) begin
          st_d = MZS_MUTED;
          dur_d = 16'h0000;
          mms_d = 10'h000;
        end
      end
      MZS_MUTED, MZS_OFFDLY: begin
        if (ms_tick) begin
          mms_d = sec_tick ? 10'h000 : mms_q + 10'h001;
        end
        if (sec_tick) begin
          dur_d = dur_q + 16'h0001;
        end
        if (st_q == MZS_MUTED) begin
          off_d = 5'h00;
          if (!both) begin
            st_d = MZS_OFFDLY;
          end
        end else if (ms_tick) begin
          off_d = off_q + 5'h01;
        end
        if (dur_q >= maxdur_q) begin
          st_d = MZS_WAIT;
          tmo_d = 1'b1;
        end else if (st_q == MZS_OFFDLY && off_q >= 5'(`MZS_OFF_MS - 1)) begin
          st_d = MZS_WAIT;
        end
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= MZS_WAIT;
      ams_q <= 14'h0000;
      dur_q <= 16'h0000;
      off_q <= 5'h00;
      mms_q <= 10'h000;
      tmo_q <= 1'b0;
      side_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ams_q <= ams_d;
      dur_q <= dur_d;
      off_q <= off_d;
      mms_q <= mms_d;
      tmo_q <= tmo_d;
      side_q <= side_d;
    end
  end

  // Outputs
  logic out_q, out_d, lamp_q, lamp_d;
  always_comb begin
    out_d = !zflt_q && (muting || !safe);
    lamp_d = muting;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
      lamp_q <= 1'b0;
    end else begin
      out_q <= out_d;
      lamp_q <= lamp_d;
    end
  end
  assign safety_switch_output = out_q;
  assign mute_lamp = lamp_q;

  // APB slave, answered in the first access cycle
  logic rdy_q, rdy_d, err_q, err_d;
  logic [31:0] rd_q, rd_d;
  logic hit, wr;
  assign hit = (paddr == `MZS_ADDR_CFG0) || (paddr == `MZS_ADDR_CFG1)
    || (paddr == `MZS_ADDR_STAT);
  assign wr = psel && penable && rdy_q && pwrite;
  always_comb begin
    rdy_d = psel && !penable;
    err_d = psel && !penable && !hit;
    rd_d = 32'h00000000;
    act_d = act_q;
    win_d = win_q;
    en_d = en_q;
    maxdur_d = maxdur_q;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `MZS_ADDR_CFG0: rd_d = {15'h0000, en_q, win_q, 4'h0, act_q};
        `MZS_ADDR_CFG1: rd_d = {16'h0000, maxdur_q};
        `MZS_ADDR_STAT: rd_d = {21'h00000, side_q, zone_q, st_q, tmo_q,
          zflt_q, muting};
        default: rd_d = 32'h00000000;
      endcase
    end
    if (wr && paddr == `MZS_ADDR_CFG0) begin
      act_d = pwdata[`MZS_ACT_LSB+:4];
      win_d = pwdata[`MZS_WIN_LSB+:8];
      en_d = pwdata[`MZS_EN_BIT];
    end
    if (wr && paddr == `MZS_ADDR_CFG1) begin
      maxdur_d = pwdata[15:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rd_q <= 32'h00000000;
      act_q <= `MZS_ACT_RST;
      win_q <= `MZS_WIN_RST;
      en_q <= `MZS_EN_RST;
      maxdur_q <= `MZS_MAXDUR_RST;
    end else begin
      rdy_q <= rdy_d;
      err_q <= err_d;
      rd_q <= rd_d;
      act_q <= act_d;
      win_q <= win_d;
      en_q <= en_d;
      maxdur_q <= maxdur_d;
    end
  end
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign prdata = rd_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence arm_both_s;
    st_q == MZS_ARMED ##0 both && en_q && !safe && !late && !$past(both);
  endsequence
  mute_entry_a: assert property (arm_both_s |=> muting)
    else $error("muting not entered");
  late_refuse_a: assert property (st_q == MZS_ARMED && late && !muting |=> !muting)
    else $error("muting after late rise");
  safe_block_a: assert property ($rose(muting) |-> !$past(safe))
    else $error("muting entered in safe state");
  timeout_end_a: assert property (muting && dur_q >= maxdur_q |=> !muting && tmo_q)
    else $error("muting not ended at timeout");
  off_bound_a: assert property (st_q == MZS_OFFDLY |-> off_q <= 5'(`MZS_OFF_MS))
    else $error("off delay too long");
  out_on_a: assert property (muting && !zflt_q |=> safety_switch_output)
    else $error("output off during muting");
  one_side_a: assert property (muting && $past(muting) |-> side_q == $past(side_q))
    else $error("muting side changed");
  lamp_show_a: assert property (##1 mute_lamp == $past(muting))
    else $error("lamp does not follow muting");
  zone_off_a: assert property (zflt_q |=> !safety_switch_output)
    else $error("output on with bad zone");
  win_tol_a: assert property (wact_q && wms_q < win_ms |=> !$rose(zflt_q))
    else $error("fault inside window");
endmodule

// file: mzs_field.sv
// Field side model: muting sensors and zone select controller
`timescale 1ns/1ps
module mzs_field #(
  parameter int MS = 4
) (
  // Clock
  input wire logic pclk,
  // Sensors and zone code
  output logic mute_a,
  output logic mute_b,
  output mzs_pkg::mzs_zone_t zone_sel
);
  import mzs_pkg::*;
  initial begin
    mute_a = 1'b0;
    mute_b = 1'b0;
    zone_sel = 4'h1;
  end
  // First sensor of a side on A, second on B
  task automatic sense(input logic a, input logic b);
    @(posedge pclk);
    mute_a <= a;
    mute_b <= b;
  endtask
  // Each code held for the processing time
  task automatic zone(input mzs_zone_t z);
    @(posedge pclk);
    zone_sel <= z;
    repeat (60 * MS) @(posedge pclk);
  endtask
endmodule

// file: mzs_ctrl_tb.sv
// Testbench of the muting and zone select block
`timescale 1ns/1ps
module mzs_ctrl_tb;
  import mzs_pkg::*;
  localparam int MS = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic object_detect = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, mute_a, mute_b, safety_switch_output, mute_lamp;
  mzs_zone_t zone_sel;
  int err_total = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic er;
  initial begin
    forever #25 pclk = ~pclk;
  end
  mzs_ctrl #(.MS_CYC(MS)) i_mzs_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mute_a(mute_a), .mute_b(mute_b),
    .zone_sel(zone_sel), .object_detect(object_detect),
    .safety_switch_output(safety_switch_output), .mute_lamp(mute_lamp));
  mzs_field #(.MS(MS)) i_mzs_field (.pclk(pclk), .mute_a(mute_a), .mute_b(mute_b),
    .zone_sel(zone_sel));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until pready is sampled high at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic od(input logic v);
    @(posedge pclk);
    object_detect <= v;
  endtask
  task automatic outs(input string what, input logic lamp, input logic on);
    #1;
    chk({what, " lamp"}, {31'h0, mute_lamp}, {31'h0, lamp});
    chk({what, " out"}, {31'h0, safety_switch_output}, {31'h0, on});
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg0", rd, 32'h0001_0403);
    apb(1'b0, 12'h004, 32'h0);
    chk("cfg1", rd, 32'h0000_0258);
    apb(1'b0, 12'h00c, 32'h0);
    chk("bad err", {31'h0, er}, 32'h1);
    chk("bad data", rd, 32'h0);
    // One second limits keep the run short
    apb(1'b1, 12'h000, 32'h0001_0400);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg0 wr", rd, 32'h0001_0400);
    apb(1'b0, 12'h004, 32'h0);
    chk("cfg1 wr", rd, 32'h0000_0001);
    $display("test regs done");
  endtask
  task automatic t_zone;
    cyc(520);
    outs("zone init", 1'b0, 1'b1);
    i_mzs_field.zone(4'h3);
    outs("zone mid", 1'b0, 1'b1);
    i_mzs_field.zone(4'h2);
    cyc(300);
    outs("zone ok", 1'b0, 1'b1);
    i_mzs_field.zone(4'hc);
    cyc(225);
    outs("zone win", 1'b0, 1'b1);
    cyc(30);
    outs("zone bad", 1'b0, 1'b0);
    i_mzs_field.zone(4'h1);
    cyc(300);
    outs("zone back", 1'b0, 1'b1);
    $display("test zone done");
  endtask
  task automatic t_mute;
    i_mzs_field.sense(1'b1, 1'b0);
    cyc(50);
    i_mzs_field.sense(1'b1, 1'b1);
    cyc(6);
    outs("mute on", 1'b1, 1'b1);
    // Muting, zone 1, state code 3, input A rose first
    apb(1'b0, 12'h008, 32'h0);
    chk("stat", rd, 32'h0000_0459);
    od(1'b1);
    i_mzs_field.sense(1'b1, 1'b0);
    cyc(100);
    outs("mute hold", 1'b1, 1'b1);
    cyc(30);
    outs("mute off", 1'b0, 1'b0);
    od(1'b0);
    i_mzs_field.sense(1'b0, 1'b0);
    $display("test mute done");
  endtask
  task automatic t_tmo;
    i_mzs_field.sense(1'b0, 1'b1);
    cyc(20);
    i_mzs_field.sense(1'b1, 1'b1);
    cyc(3990);
    outs("long", 1'b1, 1'b1);
    cyc(30);
    outs("tmo", 1'b0, 1'b0);
    i_mzs_field.sense(1'b0, 1'b0);
    cyc(10);
    outs("tmo clr", 1'b0, 1'b1);
    $display("test timeout done");
  endtask
  task automatic t_refuse;
    i_mzs_field.sense(1'b1, 1'b0);
    cyc(4100);
    i_mzs_field.sense(1'b1, 1'b1);
    cyc(10);
    outs("late", 1'b0, 1'b1);
    i_mzs_field.sense(1'b0, 1'b0);
    od(1'b1);
    cyc(10);
    i_mzs_field.sense(1'b1, 1'b1);
    cyc(10);
    outs("safe", 1'b0, 1'b0);
    od(1'b0);
    i_mzs_field.sense(1'b0, 1'b0);
    $display("test refuse done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(12);
    presetn <= 1'b1;
    t_regs;
    t_zone;
    t_mute;
    t_tmo;
    t_refuse;
    report_and_stop;
  end
  initial begin
    cyc(20000);
    err_total++;
    $display("watchdog expired");
    report_and_stop;
  end
endmodule
